// >>> hdl/opm_pkg.sv
// Constants, state codes and decode helper for the output power mask bank
`default_nettype none

package opm_pkg;

    // Serial control frame: one read flag, 15 address bits, 8 data bits
    localparam int OPM_ADDR_W = 15;
    localparam int OPM_DATA_W = 8;
    localparam logic [4:0] OPM_CNT_HDR_LAST = 5'h0F;
    localparam logic [4:0] OPM_CNT_DATA_FIRST = 5'h10;
    localparam logic [4:0] OPM_CNT_LAST = 5'h17;
    localparam logic [4:0] OPM_CNT_ONE = 5'h01;

    // Register offsets
    localparam logic [14:0] OPM_OFS_OBD0 = 15'h000A;
    localparam logic [14:0] OPM_OFS_OBD1 = 15'h000B;
    localparam logic [14:0] OPM_OFS_OBD2 = 15'h000C;
    localparam logic [14:0] OPM_OFS_MASK = 15'h000D;
    localparam logic [14:0] OPM_OFS_SREF = 15'h000E;
    localparam logic [7:0] OPM_RST_VAL = 8'h00;
    localparam logic [7:0] OPM_UNMAPPED = 8'h00;

    // Field positions of the buffer disable registers
    localparam int OPM_B0_LANE_B5 = 7;
    localparam int OPM_B0_BCLK_IN = 3;
    localparam int OPM_B1_FRAME = 4;
    localparam int OPM_B1_LANE_B6 = 0;
    localparam int OPM_B2_LANE_A6 = 1;
    localparam int OPM_B2_LANE_A5 = 0;

    // Field positions of the sleep mask and sync/reference register
    localparam int OPM_M_CLKBUF = 3;
    localparam int OPM_M_REFAMP = 2;
    localparam int OPM_M_BG_OFF = 1;
    localparam int OPM_S_REF_SRC = 3;
    localparam int OPM_S_SE_CLK = 0;

    // Serial slave states
    typedef enum logic [1:0]
    {
        OPM_ST_IDLE = 2'b00,
        OPM_ST_HDR  = 2'b01,
        OPM_ST_DATA = 2'b10,
        OPM_ST_DONE = 2'b11
    } opm_spi_state_e;

    // Address match, shared by write decode and read mux
    function automatic logic opm_hit(input logic [14:0] addr,
                                     input logic [14:0] ofs);
        opm_hit = (addr == ofs);
    endfunction

endpackage

`default_nettype wire

// >>> hdl/opm_spi_slave.sv
// Serial control port slave: frame capture, write strobe, read shift-out
`default_nettype none

module opm_spi_slave
    import opm_pkg::*;
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  nrst,
    // Serial pins
    input  wire logic                  spi_sen_n,
    input  wire logic                  spi_sclk,
    input  wire logic                  spi_sdi,
    output logic                       spi_sdout,
    output logic                       spi_sdout_oe,
    // Register side
    input  wire logic [OPM_DATA_W-1:0] rd_data,
    output logic [OPM_ADDR_W-1:0]      frame_addr,
    output logic [OPM_DATA_W-1:0]      wr_data,
    output logic                       wr_stb
);

    opm_spi_state_e   state_q;
    logic             sclk_prev_q;
    logic [4:0]       cnt_q;
    logic [14:0]      shin_q;
    logic             rd_q;
    logic [7:0]       shout_q;
    logic             rise;
    logic             fall;
    logic             first_out;
    logic [7:0]       out_src;

    // Pins are synchronous to mclk, so plain edge detection suffices;
    // sclk must be at most a quarter of mclk for a clean capture
    assign rise = spi_sclk & ~sclk_prev_q & ~spi_sen_n;
    assign fall = ~spi_sclk & sclk_prev_q & ~spi_sen_n;
    assign first_out = (cnt_q == OPM_CNT_DATA_FIRST);
    assign out_src = first_out ? rd_data : shout_q;

    ////////////////////////////////////////////////////////////////////
    // Frame sequencer; raising spi_sen_n aborts any frame at once
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            state_q      <= OPM_ST_IDLE;
            sclk_prev_q  <= 1'b0;
            cnt_q        <= '0;
            shin_q       <= '0;
            rd_q         <= 1'b0;
            shout_q      <= '0;
            frame_addr   <= '0;
            wr_data      <= '0;
            wr_stb       <= 1'b0;
            spi_sdout    <= 1'b0;
            spi_sdout_oe <= 1'b0;
        end
        else
        begin
            sclk_prev_q <= spi_sclk;
            wr_stb      <= 1'b0;
            if (spi_sen_n)
            begin
                state_q      <= OPM_ST_IDLE;
                cnt_q        <= '0;
                spi_sdout_oe <= 1'b0;
            end
            else
            begin
                unique case (state_q)
                    OPM_ST_IDLE: state_q <= OPM_ST_HDR;
                    OPM_ST_HDR:
                    begin
                        if (rise)
                        begin
                            shin_q <= {shin_q[13:0], spi_sdi};
                            cnt_q  <= cnt_q + OPM_CNT_ONE;
                            if (cnt_q == OPM_CNT_HDR_LAST)
                            begin
                                rd_q       <= shin_q[14];
                                frame_addr <= {shin_q[13:0], spi_sdi};
                                state_q    <= OPM_ST_DATA;
                            end
                        end
                    end
                    OPM_ST_DATA:
                    begin
                        // Read data leaves on falling edges, MSB first
                        if (fall)
                        begin
                            spi_sdout    <= out_src[7];
                            shout_q      <= {out_src[6:0], 1'b0};
                            spi_sdout_oe <= rd_q;
                        end
                        if (rise)
                        begin
                            shin_q <= {shin_q[13:0], spi_sdi};
                            cnt_q  <= cnt_q + OPM_CNT_ONE;
                            if (cnt_q == OPM_CNT_LAST)
                            begin
                                state_q <= OPM_ST_DONE;
                                wr_stb  <= ~rd_q;
                                wr_data <= {shin_q[6:0], spi_sdi};
                            end
                        end
                    end
                    OPM_ST_DONE: state_q <= OPM_ST_DONE;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// >>> hdl/opm_regs.sv
// Output buffer disable and global sleep mask register bank
`default_nettype none

// Behaviour
// - Each disable bit powers its output buffer down at 1, keeps it on at 0.
// - Disable map: 0x0A b7 lane B5, b3 bit clock in; 0x0B b4/b0; 0x0C b1/b0.
// - Bit clock input buffer also needs both separate enables; the output buffer follows bclk_out_off_req alone.
// - Mask bit 3 at 1 keeps the sample clock buffer on in global sleep.
// - Mask bit 2 at 1 keeps the reference amplifier on in global sleep.
// - Mask bit 1 at 1 turns the bandgap off in global sleep; 0 keeps it.
// - Global sleep request makes the mask decide which blocks turn off.
module opm_regs
    import opm_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Serial control port
    input  wire logic        spi_sen_n,
    input  wire logic        spi_sclk,
    input  wire logic        spi_sdi,
    output logic             spi_sdout,
    output logic             spi_sdout_oe,
    // Controls held in other registers of the device
    input  wire logic        global_sleep_request,
    input  wire logic        bclk_in_en_a,
    input  wire logic        bclk_in_en_b,
    input  wire logic        bclk_out_off_req,
    // Buffer power enables and the raw disable bits
    output logic             lane_b_bit5_on_q,
    output logic             bit_clock_input_on_q,
    output logic             frame_clock_output_on_q,
    output logic             lane_b_bit6_on_q,
    output logic             lane_a_bit6_on_q,
    output logic             lane_a_bit5_on_q,
    output logic             bit_clock_output_on_q,
    output logic [23:0]      output_buffer_off_bits_q,
    // Analog support enables
    output logic             sample_clock_buffer_on_q,
    output logic             reference_amplifier_on_q,
    output logic             bandgap_on_q,
    // Sync and reference control fields
    output logic [7:0]       sync_reference_control_q,
    output logic             reference_select_source_q,
    output logic             single_ended_clock_select_q
);

    import opm_pkg::*;

    logic [7:0]  obd_q [3];
    logic [7:0]  mask_q;
    logic [7:0]  sref_q;
    logic [14:0] frame_addr;
    logic [7:0]  wr_data;
    logic        wr_stb;
    logic [7:0]  rd_data;
    logic        hit0;
    logic        hit1;
    logic        hit2;
    logic        hitm;
    logic        hits;
    logic        live_q;

    ////////////////////////////////////////////////////////////////////
    // Serial port front end
    opm_spi_slave u_spi (
        .mclk         (mclk),
        .nrst         (nrst),
        .spi_sen_n    (spi_sen_n),
        .spi_sclk     (spi_sclk),
        .spi_sdi      (spi_sdi),
        .spi_sdout    (spi_sdout),
        .spi_sdout_oe (spi_sdout_oe),
        .rd_data      (rd_data),
        .frame_addr   (frame_addr),
        .wr_data      (wr_data),
        .wr_stb       (wr_stb)
    );

    ////////////////////////////////////////////////////////////////////
    // Address decode and read mux; unmapped addresses read zero
    assign hit0 = opm_hit(frame_addr, OPM_OFS_OBD0);
    assign hit1 = opm_hit(frame_addr, OPM_OFS_OBD1);
    assign hit2 = opm_hit(frame_addr, OPM_OFS_OBD2);
    assign hitm = opm_hit(frame_addr, OPM_OFS_MASK);
    assign hits = opm_hit(frame_addr, OPM_OFS_SREF);
    assign rd_data = hit0 ? obd_q[0] :
                     hit1 ? obd_q[1] :
                     hit2 ? obd_q[2] :
                     hitm ? mask_q   :
                     hits ? sref_q   : OPM_UNMAPPED;

    ////////////////////////////////////////////////////////////////////
    // Register storage; reserved bits are kept as written so readback
    // shows exactly what software put there
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            obd_q[0] <= OPM_RST_VAL;
            obd_q[1] <= OPM_RST_VAL;
            obd_q[2] <= OPM_RST_VAL;
            mask_q   <= OPM_RST_VAL;
            sref_q   <= OPM_RST_VAL;
        end
        else if (wr_stb)
        begin
            if (hit0) obd_q[0] <= wr_data;
            if (hit1) obd_q[1] <= wr_data;
            if (hit2) obd_q[2] <= wr_data;
            if (hitm) mask_q <= wr_data;
            if (hits) sref_q <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Buffer power outputs, registered so the analog side sees no glitch
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            lane_b_bit5_on_q         <= 1'b0;
            bit_clock_input_on_q     <= 1'b0;
            frame_clock_output_on_q  <= 1'b0;
            lane_b_bit6_on_q         <= 1'b0;
            lane_a_bit6_on_q         <= 1'b0;
            lane_a_bit5_on_q         <= 1'b0;
            bit_clock_output_on_q    <= 1'b0;
            output_buffer_off_bits_q <= '0;
        end
        else
        begin
            lane_b_bit5_on_q        <= ~obd_q[0][OPM_B0_LANE_B5];
            frame_clock_output_on_q <= ~obd_q[1][OPM_B1_FRAME];
            lane_b_bit6_on_q        <= ~obd_q[1][OPM_B1_LANE_B6];
            lane_a_bit6_on_q        <= ~obd_q[2][OPM_B2_LANE_A6];
            lane_a_bit5_on_q        <= ~obd_q[2][OPM_B2_LANE_A5];
            // Input buffer needs both separate enables as well
            bit_clock_input_on_q <= ~obd_q[0][OPM_B0_BCLK_IN]
                                    & bclk_in_en_a & bclk_in_en_b;
            bit_clock_output_on_q    <= ~bclk_out_off_req;
            output_buffer_off_bits_q <= {obd_q[2], obd_q[1], obd_q[0]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Global sleep gating of analog support blocks
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            sample_clock_buffer_on_q    <= 1'b0;
            reference_amplifier_on_q    <= 1'b0;
            bandgap_on_q                <= 1'b0;
            sync_reference_control_q    <= OPM_RST_VAL;
            reference_select_source_q   <= 1'b0;
            single_ended_clock_select_q <= 1'b0;
            live_q                      <= 1'b0;
        end
        else
        begin
            sample_clock_buffer_on_q <= ~global_sleep_request
                                        | mask_q[OPM_M_CLKBUF];
            reference_amplifier_on_q <= ~global_sleep_request
                                        | mask_q[OPM_M_REFAMP];
            bandgap_on_q <= ~(global_sleep_request
                              & mask_q[OPM_M_BG_OFF]);
            sync_reference_control_q    <= sref_q;
            reference_select_source_q   <= sref_q[OPM_S_REF_SRC];
            single_ended_clock_select_q <= sref_q[OPM_S_SE_CLK];
            live_q                      <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst || !live_q);

    chk_write_lands: assert property (
        wr_stb && hit0 |=> obd_q[0] == $past(wr_data))
        else $error("disable register 0 write lost");
    chk_lane_a5_map: assert property (
        wr_stb && hit2 |-> ##2 lane_a_bit5_on_q == !$past(wr_data[0], 2))
        else $error("lane A bit5 buffer not following its disable bit");
    chk_lane_b5_map: assert property (
        lane_b_bit5_on_q == !$past(obd_q[0][OPM_B0_LANE_B5]))
        else $error("lane B bit5 buffer not following its disable bit");
    chk_bclk_in_gate: assert property (
        !(bclk_in_en_a && bclk_in_en_b) |=> !bit_clock_input_on_q)
        else $error("bit clock input on without its enables");
    chk_bclk_out_ctl: assert property (
        $rose(bclk_out_off_req) |=> !bit_clock_output_on_q)
        else $error("bit clock output not powered down");
    chk_clkbuf_mask: assert property (
        global_sleep_request && !mask_q[OPM_M_CLKBUF]
        |=> !sample_clock_buffer_on_q)
        else $error("sample clock buffer left on in sleep");
    chk_refamp_mask: assert property (
        global_sleep_request && mask_q[OPM_M_REFAMP]
        |=> reference_amplifier_on_q)
        else $error("reference amplifier off despite mask");
    chk_bandgap_sense: assert property (
        bandgap_on_q == !($past(global_sleep_request)
                          && $past(mask_q[OPM_M_BG_OFF])))
        else $error("bandgap sleep sense wrong");
    chk_awake_all_on: assert property (
        !global_sleep_request |=> sample_clock_buffer_on_q
            && reference_amplifier_on_q && bandgap_on_q)
        else $error("analog block off while awake");

    cov_write_mask: cover property (wr_stb && hitm);
    cov_read_out: cover property ($rose(spi_sdout_oe));
    cov_sleep_keep: cover property (global_sleep_request
                                    && mask_q[OPM_M_CLKBUF]);

endmodule

`default_nettype wire

// >>> verification/opm_regs_bench.sv
// Self-checking bench for the output power mask register bank
`default_nettype none

module opm_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import opm_pkg::*;

    // Stimulus and observed signals
    logic        mclk;
    logic        nrst;
    logic        spi_sen_n;
    logic        spi_sclk;
    logic        spi_sdi;
    logic        spi_sdout;
    logic        spi_sdout_oe;
    logic        sleep;
    logic        en_a;
    logic        en_b;
    logic        off_req;
    logic [5:0]  bon;
    logic [2:0]  aon;
    logic [1:0]  bclk;
    logic [23:0] off_bits;
    logic [7:0]  sref;
    logic [1:0]  sfld;
    int          n_fail;
    int          checks;

    // Grouped views of the enables, padded for the single compare task
    wire logic [23:0] buf_on  = {18'h0, bon};
    wire logic [23:0] an_on   = {21'h0, aon};
    wire logic [23:0] bclk_on = {22'h0, bclk};
    wire logic [23:0] sref_v  = {14'h0, sfld, sref};

    opm_regs u_opm_regs (
        .mclk                        (mclk),
        .nrst                        (nrst),
        .spi_sen_n                   (spi_sen_n),
        .spi_sclk                    (spi_sclk),
        .spi_sdi                     (spi_sdi),
        .spi_sdout                   (spi_sdout),
        .spi_sdout_oe                (spi_sdout_oe),
        .global_sleep_request        (sleep),
        .bclk_in_en_a                (en_a),
        .bclk_in_en_b                (en_b),
        .bclk_out_off_req            (off_req),
        .lane_b_bit5_on_q            (bon[5]),
        .bit_clock_input_on_q        (bon[4]),
        .frame_clock_output_on_q     (bon[3]),
        .lane_b_bit6_on_q            (bon[2]),
        .lane_a_bit6_on_q            (bon[1]),
        .lane_a_bit5_on_q            (bon[0]),
        .bit_clock_output_on_q       (bclk[0]),
        .output_buffer_off_bits_q    (off_bits),
        .sample_clock_buffer_on_q    (aon[2]),
        .reference_amplifier_on_q    (aon[1]),
        .bandgap_on_q                (aon[0]),
        .sync_reference_control_q    (sref),
        .reference_select_source_q   (sfld[1]),
        .single_ended_clock_select_q (sfld[0])
    );
    assign bclk[1] = bon[4];

    ////////////////////////////////////////////////////////////////////////
    // Clock, 4 ns period
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Common compare; four-state, so an unknown matches only an unknown
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One serial frame of n bits; each sclk phase lasts 3 mclk so the
    // slave's edge detector always sees it. Read bits sampled before rise.
    task automatic xfer(input logic rd, input logic [14:0] a,
                        input logic [7:0] wd, input int n,
                        output logic [7:0] rq);
        logic [23:0] f;
        f = {rd, a, wd};
        rq = 8'h00;
        spi_sen_n = 1'b0;
        for (int i = 23; i >= 24 - n; i--)
        begin
            spi_sdi = f[i];
            repeat (3) @(posedge mclk);
            #1;
            // Output enable must stand only through a read data phase
            if (i < 8)
            begin
                rq = {rq[6:0], spi_sdout};
                chk({23'h0, spi_sdout_oe}, {23'h0, rd});
            end
            spi_sclk = 1'b1;
            repeat (3) @(posedge mclk);
            #1 spi_sclk = 1'b0;
        end
        repeat (3) @(posedge mclk);
        #1 spi_sen_n = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        chk({23'h0, spi_sdout_oe}, 24'h0);
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] rq;
        xfer(1'b0, a, d, 24, rq);
    endtask

    task automatic rdchk(input logic [14:0] a, input logic [7:0] exp);
        logic [7:0] rq;
        xfer(1'b1, a, 8'h00, 24, rq);
        chk({16'h0, rq}, {16'h0, exp});
    endtask

    // Expected lane enables with both bit clock input enables high
    function automatic logic [23:0] buf_exp(input logic [23:0] v);
        return {18'h0, ~{v[7], v[3], v[12], v[8], v[17], v[16]}};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        rdchk(OPM_OFS_OBD0, 8'h00);
        rdchk(OPM_OFS_OBD1, 8'h00);
        rdchk(OPM_OFS_OBD2, 8'h00);
        rdchk(OPM_OFS_MASK, 8'h00);
        rdchk(OPM_OFS_SREF, 8'h00);
        chk(buf_on, 24'h00003F);
        chk(an_on, 24'h000007);
    endtask

    // Every mode table plus a pattern that flips each mapped bit
    task automatic t_modes;
        logic [23:0] tbl [4];
        tbl = '{24'hFCEE7F, 24'hFDEEFF, 24'hFDEFFF, 24'h021080};
        foreach (tbl[m])
        begin
            wr(OPM_OFS_OBD0, tbl[m][7:0]);
            wr(OPM_OFS_OBD1, tbl[m][15:8]);
            wr(OPM_OFS_OBD2, tbl[m][23:16]);
            rdchk(OPM_OFS_OBD0, tbl[m][7:0]);
            rdchk(OPM_OFS_OBD1, tbl[m][15:8]);
            rdchk(OPM_OFS_OBD2, tbl[m][23:16]);
            chk(off_bits, tbl[m]);
            chk(buf_on, buf_exp(tbl[m]));
        end
    endtask

    // Bit clock buffers follow their own enables while disable bit 3 of 0x0A stays clear
    task automatic t_bclk;
        for (int i = 0; i < 8; i++)
        begin
            {en_a, en_b, off_req} = i[2:0];
            repeat (2) @(posedge mclk);
            #1;
            chk(bclk_on, {22'h0, en_a & en_b, ~off_req});
            chk(off_bits, 24'h021080);
        end
        {en_a, en_b, off_req} = 3'b110;
    endtask

    // Every combination of mask bits 3 to 1 with sleep off and on
    task automatic t_mask;
        logic [7:0] m;
        logic       s;
        logic [2:0] e;
        for (int i = 0; i < 16; i++)
        begin
            s = i[3];
            m = {4'h0, i[2:0], 1'b0};
            sleep = s;
            wr(OPM_OFS_MASK, m);
            // Clock buffer and amplifier keep at 1; bandgap bit is inverted
            e = {~(s & ~m[3]), ~(s & ~m[2]), ~(s & m[1])};
            chk(an_on, {21'h0, e});
        end
    endtask

    // Reserved bits store and read back; fields of the sync register
    task automatic t_reserved;
        wr(OPM_OFS_MASK, 8'hF1);
        rdchk(OPM_OFS_MASK, 8'hF1);
        chk(an_on, 24'h000001);
        sleep = 1'b0;
        wr(OPM_OFS_SREF, 8'hE9);
        rdchk(OPM_OFS_SREF, 8'hE9);
        chk(sref_v, 24'h0003E9);
        wr(OPM_OFS_SREF, 8'h16);
        chk(sref_v, 24'h000016);
    endtask

    // Unmapped addresses, one differing from 0x0A only in bit 14, then a frame cut short
    task automatic t_refuse;
        logic [7:0] rq;
        wr(15'h000F, 8'hFF);
        rdchk(15'h000F, 8'h00);
        wr(15'h400A, 8'hFF);
        rdchk(15'h400A, 8'h00);
        xfer(1'b0, OPM_OFS_OBD0, 8'h55, 20, rq);
        rdchk(OPM_OFS_OBD0, 8'h80);
        chk(buf_on, buf_exp(24'h021080));
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset for 3 cycles, then the scenarios
    initial
    begin
        n_fail = 0;
        checks = 0;
        nrst = 1'b0;
        spi_sen_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi = 1'b0;
        sleep = 1'b0;
        {en_a, en_b, off_req} = 3'b110;
        repeat (3) @(posedge mclk);
        #1 nrst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        t_reset;
        t_modes;
        t_bclk;
        t_mask;
        t_reserved;
        t_refuse;
        conclude;
    end

    // Watchdog: about 60 frames of 160 cycles fit well inside this span
    initial
    begin
        #200000;
        n_fail++;
        conclude;
    end

endmodule

`default_nettype wire
